// [common/csi2_lane_pkg.sv]
// constants and types of the csi-2 lane burst sequencer
// assumes a 20 mhz system clock and a 30 ns byte clock on the link side
package csi2_lane_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] TIMING_A_OFS = 8'h6C;
  localparam logic [7:0] TIMING_B_OFS = 8'h6D;
  localparam logic [7:0] STATUS_OFS   = 8'h6E;
  localparam logic [7:0] TIMING_RST   = 8'h00;
  localparam int         EXTRA_LSB    = 0;
  localparam int         EXTRA_MSB    = 3;

  // ****************************************
  // timing, in ps, wake-up in ms
  // ****************************************
  localparam int CLK_PS          = 50000;
  localparam int UI_PS           = 3750;
  localparam int T_PREP_MIN_PS   = 40 * 1000 + 4 * UI_PS;
  localparam int T_PREP_MAX_PS   = 85 * 1000 + 6 * UI_PS;
  localparam int T_PZ_MIN_PS     = 145 * 1000 + 10 * UI_PS;
  localparam int T_TRAIL_MIN_PS  = 60 * 1000 + 4 * UI_PS;
  localparam int T_EOT_MAX_PS    = 105 * 1000 + 12 * UI_PS;
  localparam int T_LPX_PS        = 50 * 1000;
  localparam int T_CPRE_PS       = 8 * UI_PS;
  localparam int T_CPZ_PS        = 300 * 1000;
  localparam int T_CTRAIL_PS     = 60 * 1000;
  localparam int T_EXIT_PS       = 100 * 1000;
  localparam int T_WAKEUP_MS     = 1;

  // ****************************************
  // cycle counts
  // ****************************************
  localparam int PREP_CYC   = (T_PREP_MIN_PS + CLK_PS - 1) / CLK_PS;
  localparam int ZERO_CYC   = (T_PZ_MIN_PS + CLK_PS - 1) / CLK_PS - PREP_CYC;
  localparam int TRAIL_CYC  = (T_TRAIL_MIN_PS + CLK_PS - 1) / CLK_PS;
  localparam int LPX_CYC    = (T_LPX_PS + CLK_PS - 1) / CLK_PS;
  localparam int CPRE_CYC   = (T_CPRE_PS + CLK_PS - 1) / CLK_PS;
  localparam int CPZ_CYC    = (T_CPZ_PS + CLK_PS - 1) / CLK_PS;
  localparam int CTRAIL_CYC = (T_CTRAIL_PS + CLK_PS - 1) / CLK_PS;
  localparam int EXIT_CYC   = (T_EXIT_PS + CLK_PS - 1) / CLK_PS;
  localparam int WAKEUP_DEF = T_WAKEUP_MS * 1000000000 / CLK_PS;

  // ****************************************
  // line states and codes
  // ****************************************
  localparam logic [1:0] LP11      = 2'b11;
  localparam logic [1:0] LP01      = 2'b01;
  localparam logic [1:0] LP00      = 2'b00;
  localparam logic [1:0] LP10      = 2'b10;
  localparam logic [7:0] SYNC_BYTE = 8'hB8;

  typedef enum logic [14:0] {
    S_STOP   = 15'h0001,
    S_CREQ   = 15'h0002,
    S_CBRG   = 15'h0004,
    S_CHS    = 15'h0008,
    S_DREQ   = 15'h0010,
    S_DBRG   = 15'h0020,
    S_PREP   = 15'h0040,
    S_ZERO   = 15'h0080,
    S_SYNC   = 15'h0100,
    S_PAY    = 15'h0200,
    S_TRAIL  = 15'h0400,
    S_CTRAIL = 15'h0800,
    S_EXIT   = 15'h1000,
    S_ULPS   = 15'h2000,
    S_WAKE   = 15'h4000
  } seq_t;

  typedef struct packed {
    logic [1:0] lp;
    logic       hs_en;
  } lane_ctl_t;

endpackage : csi2_lane_pkg

// [design/csi2_lane_burst_timing.sv]
// csi-2 transmit lane sequencer: lp/hs line states and round-robin payload
// assumes an analog phy that turns lane_ctl_t and hs bytes into line levels
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// three-stage input synchroniser
// ****************************************
module csi2_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q_o  <= '0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_o  <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & q_o);
    end
  end
endmodule : csi2_sync3

// Functional notes
// - prepare state lasts 40+4UI to 85+6UI ns
// - prepare plus zero at least 145+10UI ns
// - trailer held at least 60+4UI ns
// - every lp state held at least 50 ns
// - ulps exit waits at least 1 ms
// - four lanes plus clock, or replicated port
// - pixel clock 25-96 or 50-170 mhz
// - clock runs 8 UI before data entry
// - clock drives zero 60 ns after data
// - trailer start to stop within 105+12UI
module csi2_lane_burst_timing #(
  parameter int unsigned WAKEUP_CYC = csi2_lane_pkg::WAKEUP_DEF
) (
  // clocks and reset
  input  wire logic                            sys_clk_i,
  input  wire logic                            rst_b_i,
  input  wire logic                            hs_clk_i,
  // register port
  input  wire logic                            reg_wr_i,
  input  wire logic [7:0]                      reg_addr_i,
  input  wire logic [7:0]                      reg_wdata_i,
  output logic      [7:0]                      reg_rdata_o,
  // configuration
  input  wire logic                            four_lane_i,
  input  wire logic                            replicate_i,
  input  wire logic                            ulps_req_i,
  // payload, byte clock domain
  input  wire logic [7:0]                      pay_data_i,
  input  wire logic                            pay_valid_i,
  input  wire logic                            pay_last_i,
  output logic                                 pay_ready_o,
  // lanes
  output csi2_lane_pkg::lane_ctl_t [1:0]       clk_lane_o,
  output csi2_lane_pkg::lane_ctl_t [7:0]       dat_lane_o,
  output logic                     [7:0][7:0]  dat_hs_o
);

  // ****************************************
  // registers
  // ****************************************
  logic [7:0]          ta_q;
  logic [7:0]          tb_q;
  csi2_lane_pkg::seq_t st_q;
  csi2_lane_pkg::seq_t st_d;
  logic [14:0]         cnt_q;
  logic [14:0]         cnt_d;
  logic                req_s;
  logic                done_s;
  logic                go_q;
  logic                hs_done_q;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ta_q <= csi2_lane_pkg::TIMING_RST;
      tb_q <= csi2_lane_pkg::TIMING_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == csi2_lane_pkg::TIMING_A_OFS) begin
        ta_q <= reg_wdata_i;
      end
      if (reg_addr_i == csi2_lane_pkg::TIMING_B_OFS) begin
        tb_q <= reg_wdata_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      case (reg_addr_i)
        csi2_lane_pkg::TIMING_A_OFS: reg_rdata_o <= ta_q;
        csi2_lane_pkg::TIMING_B_OFS: reg_rdata_o <= tb_q;
        csi2_lane_pkg::STATUS_OFS: begin
          reg_rdata_o <= {6'h00, st_q == csi2_lane_pkg::S_ULPS, st_q != csi2_lane_pkg::S_STOP};
        end
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // crossings into the system domain
  // ****************************************
  logic [1:0] to_sys;

  csi2_sync3 #(.W(2)) u_sync_sys (
    .clk_i   (sys_clk_i),
    .rst_b_i (rst_b_i),
    .d_i     ({hs_done_q, pay_valid_i}),
    .q_o     (to_sys)
  );

  assign req_s  = to_sys[0];
  assign done_s = to_sys[1];

  // ****************************************
  // burst sequencer
  // ****************************************
  function automatic logic [14:0] ld(input int unsigned n);
    ld = 15'(n - 1);
  endfunction : ld

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q - 15'h0001;
    if (cnt_q == 15'h0000) begin
      cnt_d = 15'h0000;
      case (st_q)
        csi2_lane_pkg::S_STOP: begin
          if (ulps_req_i) begin
            st_d  = csi2_lane_pkg::S_ULPS;
            cnt_d = ld(csi2_lane_pkg::LPX_CYC);
          end else if (req_s) begin
            st_d  = csi2_lane_pkg::S_CREQ;
            cnt_d = ld(csi2_lane_pkg::LPX_CYC);
          end
        end
        csi2_lane_pkg::S_CREQ: begin
          st_d  = csi2_lane_pkg::S_CBRG;
          cnt_d = ld(csi2_lane_pkg::LPX_CYC);
        end
        csi2_lane_pkg::S_CBRG: begin
          st_d  = csi2_lane_pkg::S_CHS;
          cnt_d = ld(csi2_lane_pkg::CPZ_CYC + csi2_lane_pkg::CPRE_CYC);
        end
        csi2_lane_pkg::S_CHS: begin
          st_d  = csi2_lane_pkg::S_DREQ;
          cnt_d = ld(csi2_lane_pkg::LPX_CYC);
        end
        csi2_lane_pkg::S_DREQ: begin
          st_d  = csi2_lane_pkg::S_DBRG;
          cnt_d = ld(csi2_lane_pkg::LPX_CYC);
        end
        csi2_lane_pkg::S_DBRG: begin
          st_d  = csi2_lane_pkg::S_PREP;
          cnt_d = ld(csi2_lane_pkg::PREP_CYC);
        end
        csi2_lane_pkg::S_PREP: begin
          st_d  = csi2_lane_pkg::S_ZERO;
          cnt_d = ld(csi2_lane_pkg::ZERO_CYC + int'(ta_q[csi2_lane_pkg::EXTRA_MSB:csi2_lane_pkg::EXTRA_LSB]));
        end
        csi2_lane_pkg::S_ZERO: begin
          st_d  = csi2_lane_pkg::S_SYNC;
          cnt_d = 15'h0000;
        end
        csi2_lane_pkg::S_SYNC: begin
          st_d = csi2_lane_pkg::S_PAY;
        end
        csi2_lane_pkg::S_PAY: begin
          if (done_s) begin
            st_d  = csi2_lane_pkg::S_TRAIL;
            cnt_d = ld(csi2_lane_pkg::TRAIL_CYC);
          end
        end
        csi2_lane_pkg::S_TRAIL: begin
          st_d  = csi2_lane_pkg::S_CTRAIL;
          cnt_d = ld(csi2_lane_pkg::CTRAIL_CYC);
        end
        csi2_lane_pkg::S_CTRAIL: begin
          st_d  = csi2_lane_pkg::S_EXIT;
          cnt_d = ld(csi2_lane_pkg::EXIT_CYC + int'(tb_q[csi2_lane_pkg::EXTRA_MSB:csi2_lane_pkg::EXTRA_LSB]));
        end
        csi2_lane_pkg::S_EXIT: begin
          st_d = csi2_lane_pkg::S_STOP;
        end
        csi2_lane_pkg::S_ULPS: begin
          if (!ulps_req_i) begin
            st_d  = csi2_lane_pkg::S_WAKE;
            cnt_d = ld(WAKEUP_CYC);
          end
        end
        csi2_lane_pkg::S_WAKE: begin
          st_d = csi2_lane_pkg::S_STOP;
        end
        default: st_d = csi2_lane_pkg::S_STOP;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q  <= csi2_lane_pkg::S_STOP;
      cnt_q <= 15'h0000;
      go_q  <= 1'b0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      go_q  <= (st_d == csi2_lane_pkg::S_SYNC) || (st_d == csi2_lane_pkg::S_PAY);
    end
  end

  // ****************************************
  // line states
  // ****************************************
  csi2_lane_pkg::lane_ctl_t cc;
  csi2_lane_pkg::lane_ctl_t dc;
  csi2_lane_pkg::lane_ctl_t stop_c;

  assign stop_c = '{lp: csi2_lane_pkg::LP11, hs_en: 1'b0};

  always_comb begin
    cc = stop_c;
    dc = stop_c;
    case (st_d)
      csi2_lane_pkg::S_CREQ:   cc.lp = csi2_lane_pkg::LP01;
      csi2_lane_pkg::S_CBRG:   cc.lp = csi2_lane_pkg::LP00;
      csi2_lane_pkg::S_CHS:    cc = '{lp: csi2_lane_pkg::LP00, hs_en: 1'b1};
      csi2_lane_pkg::S_DREQ: begin
        cc = '{lp: csi2_lane_pkg::LP00, hs_en: 1'b1};
        dc.lp = csi2_lane_pkg::LP01;
      end
      csi2_lane_pkg::S_DBRG, csi2_lane_pkg::S_PREP: begin
        cc = '{lp: csi2_lane_pkg::LP00, hs_en: 1'b1};
        dc.lp = csi2_lane_pkg::LP00;
      end
      csi2_lane_pkg::S_ZERO, csi2_lane_pkg::S_SYNC, csi2_lane_pkg::S_PAY, csi2_lane_pkg::S_TRAIL: begin
        cc = '{lp: csi2_lane_pkg::LP00, hs_en: 1'b1};
        dc = '{lp: csi2_lane_pkg::LP00, hs_en: 1'b1};
      end
      csi2_lane_pkg::S_CTRAIL: cc = '{lp: csi2_lane_pkg::LP00, hs_en: 1'b1};
      csi2_lane_pkg::S_ULPS: begin
        cc.lp = csi2_lane_pkg::LP00;
        dc.lp = csi2_lane_pkg::LP00;
      end
      csi2_lane_pkg::S_WAKE: begin
        cc.lp = csi2_lane_pkg::LP10;
        dc.lp = csi2_lane_pkg::LP10;
      end
      default: begin
        cc = stop_c;
        dc = stop_c;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clk_lane_o <= {2{csi2_lane_pkg::LP11, 1'b0}};
      dat_lane_o <= {8{csi2_lane_pkg::LP11, 1'b0}};
    end else begin
      clk_lane_o[0] <= cc;
      clk_lane_o[1] <= replicate_i ? cc : stop_c;
      for (int k = 0; k < 4; k++) begin
        dat_lane_o[k]   <= (k < 2 || four_lane_i) ? dc : stop_c;
        dat_lane_o[k+4] <= (replicate_i && (k < 2 || four_lane_i)) ? dc : stop_c;
      end
    end
  end

  // ****************************************
  // byte clock domain
  // ****************************************
  logic [1:0]      hrst_q;
  logic [1:0]      to_hs;
  logic            go_d1_q;
  logic            act_q;
  logic            trl_q;
  logic [1:0]      idx_q;
  logic [1:0]      nlast;
  logic [3:0][7:0] stg_q;
  logic [3:0][7:0] out_q;

  always_ff @(posedge hs_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hrst_q <= 2'b00;
    end else begin
      hrst_q <= {hrst_q[0], 1'b1};
    end
  end

  csi2_sync3 #(.W(2)) u_sync_hs (
    .clk_i   (hs_clk_i),
    .rst_b_i (hrst_q[1]),
    .d_i     ({four_lane_i, go_q}),
    .q_o     (to_hs)
  );

  assign nlast = to_hs[1] ? 2'h3 : 2'h1;

  always_ff @(posedge hs_clk_i or negedge hrst_q[1]) begin
    if (!hrst_q[1]) begin
      go_d1_q     <= 1'b0;
      act_q       <= 1'b0;
      hs_done_q   <= 1'b0;
      trl_q       <= 1'b0;
      idx_q       <= 2'h0;
      stg_q       <= '0;
      out_q       <= '0;
      pay_ready_o <= 1'b0;
    end else begin
      go_d1_q <= to_hs[0];
      if (!to_hs[0]) begin
        act_q       <= 1'b0;
        hs_done_q   <= 1'b0;
        trl_q       <= 1'b0;
        idx_q       <= 2'h0;
        out_q       <= '0;
        pay_ready_o <= 1'b0;
      end else if (!go_d1_q) begin
        out_q       <= {4{csi2_lane_pkg::SYNC_BYTE}};
        act_q       <= 1'b1;
        pay_ready_o <= 1'b1;
      end else if (act_q && pay_valid_i && pay_ready_o) begin
        stg_q[idx_q] <= pay_data_i;
        idx_q        <= (idx_q == nlast) ? 2'h0 : idx_q + 2'h1;
        if (idx_q == nlast || pay_last_i) begin
          for (int k = 0; k < 4; k++) begin
            out_q[k] <= (k == int'(idx_q)) ? pay_data_i : (k < int'(idx_q) ? stg_q[k] : 8'h00);
          end
        end
        if (pay_last_i) begin
          act_q       <= 1'b0;
          hs_done_q   <= 1'b1;
          pay_ready_o <= 1'b0;
        end
      end else if (hs_done_q && !trl_q) begin
        trl_q <= 1'b1;
        for (int k = 0; k < 4; k++) begin
          out_q[k] <= {8{~out_q[k][7]}};
        end
      end
    end
  end

  always_ff @(posedge hs_clk_i or negedge hrst_q[1]) begin
    if (!hrst_q[1]) begin
      dat_hs_o <= '0;
    end else begin
      dat_hs_o <= {out_q, out_q};
    end
  end

endmodule : csi2_lane_burst_timing

`default_nettype wire

// [verification/csi2_lane_monitor.sv]
// concurrent checks on the lane sequencer outputs, bound to its top
// assumes lanes and inputs watched here all live in the sys clock domain
`timescale 1ns/100ps
`default_nettype none
module csi2_lane_monitor #(
  parameter int unsigned WAKEUP_CYC = 20
) (
  // clock and reset
  input wire logic                           sys_clk_i,
  input wire logic                           rst_b_i,
  // configuration
  input wire logic                           four_lane_i,
  input wire logic                           replicate_i,
  // lanes
  input wire csi2_lane_pkg::lane_ctl_t [1:0] clk_lane_o,
  input wire csi2_lane_pkg::lane_ctl_t [7:0] dat_lane_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire logic [1:0]  dlp = dat_lane_o[0].lp;
  wire logic [1:0]  clp = clk_lane_o[0].lp;
  wire logic        dhs = dat_lane_o[0].hs_en;
  wire logic        chs = clk_lane_o[0].hs_en;
  logic      [15:0] wake_q;
  // length of the current wake-up drive
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) wake_q <= 16'h0000;
    else if (clp == csi2_lane_pkg::LP10) wake_q <= wake_q + 16'h0001;
    else wake_q <= 16'h0000;
  end
  sequence lane_req_s;
    dlp == csi2_lane_pkg::LP01 ##1 dlp == csi2_lane_pkg::LP00;
  endsequence
  sequence prep_s;
    (dlp == csi2_lane_pkg::LP00 && !dhs) [*3] ##1 dhs;
  endsequence
  prep_len_a: assert property (lane_req_s |-> prep_s)
    else $error("prepare length wrong");
  zero_len_a: assert property ($rose(dhs) |-> dhs [*4])
    else $error("zero drive too short");
  hs_entry_a: assert property ($rose(dhs) |-> $past(dlp, 4) == csi2_lane_pkg::LP01)
    else $error("hs entry without request");
  exit_stop_a: assert property ($fell(dhs) |-> (dlp == csi2_lane_pkg::LP11) [*2])
    else $error("no stop after trailer");
  clk_pre_a: assert property ($rose(dlp == csi2_lane_pkg::LP01) |-> chs && $past(chs, 7))
    else $error("clock not running before data entry");
  clk_trail_a: assert property ($fell(chs) |-> $past(dlp, 2) == csi2_lane_pkg::LP11 && !$past(dhs))
    else $error("clock stopped before data exit");
  wake_len_a: assert property ($past(clp) == csi2_lane_pkg::LP10 && clp != csi2_lane_pkg::LP10
    |-> 32'(wake_q) >= WAKEUP_CYC)
    else $error("wake-up interval short");
  lane_sync_a: assert property (dat_lane_o[1] == dat_lane_o[0]
    && (!four_lane_i || !$past(four_lane_i) || dat_lane_o[3:2] == {2{dat_lane_o[0]}}))
    else $error("data lanes out of step");
  port_copy_a: assert property (replicate_i && $past(replicate_i)
    |-> dat_lane_o[5:4] == dat_lane_o[1:0] && clk_lane_o[1] == clk_lane_o[0])
    else $error("second port not a copy");
endmodule : csi2_lane_monitor
bind csi2_lane_burst_timing csi2_lane_monitor #(.WAKEUP_CYC(WAKEUP_CYC)) mon (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .four_lane_i(four_lane_i),
  .replicate_i(replicate_i), .clk_lane_o(clk_lane_o), .dat_lane_o(dat_lane_o));
`default_nettype wire

// [verification/csi2_rx_model.sv]
// receiver model: counts bursts and keeps the first payload byte per lane
// assumes lane 0 hs_en marks the burst and bytes arrive on the link clock
`timescale 1ns/100ps
`default_nettype none
module csi2_rx_model (
  // clock and reset
  input wire logic                           hs_clk_i,
  input wire logic                           rst_b_i,
  // lanes
  input wire csi2_lane_pkg::lane_ctl_t [7:0] dat_lane_i,
  input wire logic [7:0][7:0]                dat_hs_i,
  // results
  output logic     [7:0]                     burst_cnt_o,
  output logic     [3:0][7:0]                first_o
);
  logic sync_q;
  logic got_q;
  always_ff @(posedge hs_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_q      <= 1'b0;
      got_q       <= 1'b0;
      burst_cnt_o <= 8'h00;
      first_o     <= '0;
    end else if (!dat_lane_i[0].hs_en) begin
      sync_q <= 1'b0;
      got_q  <= 1'b0;
    end else if (!sync_q && dat_hs_i[0] == csi2_lane_pkg::SYNC_BYTE) begin
      sync_q      <= 1'b1;
      burst_cnt_o <= burst_cnt_o + 8'h01;
    end else if (sync_q && !got_q && dat_hs_i[0] != csi2_lane_pkg::SYNC_BYTE) begin
      got_q   <= 1'b1;
      first_o <= dat_hs_i[3:0];
    end
  end
endmodule : csi2_rx_model
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench: register port, bursts in four and two lanes, ulps
// assumes a shortened wake-up count and a free link clock of 30 ns
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int unsigned WK = 20;
  logic sys_clk_i, rst_b_i, hs_clk_i, reg_wr_i, four_lane_i, replicate_i, ulps_req_i;
  logic pay_valid_i, pay_last_i, pay_ready_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, pay_data_i, burst_cnt;
  csi2_lane_pkg::lane_ctl_t [1:0] clk_lane_o;
  csi2_lane_pkg::lane_ctl_t [7:0] dat_lane_o;
  logic [7:0][7:0] dat_hs_o;
  logic [3:0][7:0] first;
  int mismatches, checked;
  csi2_lane_burst_timing #(.WAKEUP_CYC(WK)) dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .hs_clk_i(hs_clk_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .four_lane_i(four_lane_i), .replicate_i(replicate_i),
    .ulps_req_i(ulps_req_i), .pay_data_i(pay_data_i), .pay_valid_i(pay_valid_i),
    .pay_last_i(pay_last_i), .pay_ready_o(pay_ready_o), .clk_lane_o(clk_lane_o),
    .dat_lane_o(dat_lane_o), .dat_hs_o(dat_hs_o));
  csi2_rx_model rx (.hs_clk_i(hs_clk_i), .rst_b_i(rst_b_i), .dat_lane_i(dat_lane_o),
    .dat_hs_i(dat_hs_o), .burst_cnt_o(burst_cnt), .first_o(first));
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    hs_clk_i = 1'b0;
    #7;
    forever #15 hs_clk_i = ~hs_clk_i;
  end
  task automatic finish_test;
    if (mismatches == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic hang;
    mismatches++;
    $display("[FAIL] %0t wait ran out", $time);
    finish_test();
  endtask : hang
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge sys_clk_i);
    reg_wr_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk_i);
    reg_addr_i = a;
    @(negedge sys_clk_i);
    d = reg_rdata_o;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask : rdc
  task automatic send(input int cnt);
    int i;
    i = 0;
    @(negedge hs_clk_i);
    pay_valid_i = 1'b1;
    pay_data_i = 8'h41;
    pay_last_i = (cnt == 1);
    for (int t = 0; t < 2000 && i < cnt; t++) begin
      @(posedge hs_clk_i);
      if (pay_ready_o === 1'b1) i++;
      @(negedge hs_clk_i);
      pay_data_i = 8'h41 + 8'(i);
      pay_last_i = (i == cnt - 1);
    end
    pay_valid_i = 1'b0;
    pay_last_i = 1'b0;
    if (i < cnt) hang();
  endtask : send
  task automatic poll(input logic [7:0] mask, input logic [7:0] want);
    logic [7:0] s;
    for (int t = 0; t < 300; t++) begin
      rd(csi2_lane_pkg::STATUS_OFS, s);
      if ((s & mask) === want) return;
    end
    hang();
  endtask : poll
  initial begin
    int n;
    logic [7:0] wv [4];
    wv = '{8'h89, 8'h83, 8'h82, 8'h84};
    {reg_wr_i, ulps_req_i, pay_valid_i, pay_last_i} = 4'h0;
    {reg_addr_i, reg_wdata_i, pay_data_i} = 24'h000000;
    four_lane_i = 1'b1;
    replicate_i = 1'b1;
    mismatches = 0;
    checked = 0;
    rst_b_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    rst_b_i = 1'b1;
    rdc(csi2_lane_pkg::TIMING_A_OFS, 8'h00);
    rdc(csi2_lane_pkg::TIMING_B_OFS, 8'h00);
    rdc(8'h10, 8'h00);
    wr(csi2_lane_pkg::STATUS_OFS, 8'hFF);
    rdc(csi2_lane_pkg::STATUS_OFS, 8'h00);
    wr(csi2_lane_pkg::TIMING_A_OFS, 8'h02);
    rdc(csi2_lane_pkg::TIMING_A_OFS, 8'h02);
    foreach (wv[k]) begin
      wr(csi2_lane_pkg::TIMING_B_OFS, wv[k]);
      rdc(csi2_lane_pkg::TIMING_B_OFS, wv[k]);
    end
    // four lanes, second port replicated
    send(8);
    poll(8'h01, 8'h00);
    for (int k = 0; k < 4; k++) chk(first[k], 8'h41 + 8'(k));
    chk(burst_cnt, 8'h01);
    // two lanes, single port
    wr(csi2_lane_pkg::TIMING_B_OFS, 8'h83);
    four_lane_i = 1'b0;
    replicate_i = 1'b0;
    send(6);
    poll(8'h01, 8'h00);
    chk(first[0], 8'h41);
    chk(first[1], 8'h42);
    chk(burst_cnt, 8'h02);
    chk(8'(dat_lane_o[4].lp), 8'(csi2_lane_pkg::LP11));
    // ultra-low-power entry and wake-up
    @(negedge sys_clk_i);
    ulps_req_i = 1'b1;
    poll(8'h02, 8'h02);
    chk(8'(clk_lane_o[0].lp), 8'(csi2_lane_pkg::LP00));
    ulps_req_i = 1'b0;
    n = 0;
    while (clk_lane_o[0].lp !== csi2_lane_pkg::LP11 && n < 300) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk({7'h00, n > WK}, 8'h01);
    chk({7'h00, n < 300}, 8'h01);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
